// ==== src/cptfb_map.vh ====
`ifndef CPTFB_MAP_VH
`define CPTFB_MAP_VH
// register byte offsets
`define CPTFB_REG_CMD      8'h00
`define CPTFB_REG_STATUS   8'h04
`define CPTFB_REG_VALID    8'h08
`define CPTFB_REG_MAP      8'h0c
// axi responses
`define CPTFB_RESP_OKAY    2'h0
`define CPTFB_RESP_SLVERR  2'h2
// command words
`define CPTFB_CMD_SEL_HI   14'h1455
`define CPTFB_CMD_ENE_HI   12'h516
`define CPTFB_CMD_MAP_HI   12'h517
`define CPTFB_CMD_RESTORE  16'h515d
// field positions of a command word
`define CPTFB_FLD_FILT     3:2
`define CPTFB_FLD_IDX      1:0
`define CPTFB_FLD_MAPV     3:0
// frame timing in samples
`define CPTFB_FRAME_LAST   8'hef
`define CPTFB_HALF_LAST    8'h77
// energy scaling shift (divide by 32)
`define CPTFB_SCALE_SH     5
// fixed set detection parameters
`define CPTFB_THR_FIX      16'h009f
`define CPTFB_RATIO_FIX    16'h0015
`define CPTFB_HCTL_FIX     16'h0ff5
`define CPTFB_FIRST_FIXED  4'h4
// reset values
`define CPTFB_MAP_RST      16'h3210
`define CPTFB_SEL_RST      2'h0
`define CPTFB_STATUS_RST   16'h0000
`endif

// ==== src/cptfb_tone_filter_bank.v ====
// What this block does
// [R1] energy read word 516x: filter in bits 3-2, word index in bits 1-0
// [R2] energy read answers one 16-bit word: broad low, broad high, band low, band high
// [R3] one 32-bit broadband energy for all filters, and a 32-bit in-band energy per filter
// [R4] energy over 240 samples: sample/4 squared, summed, divided by 32
// [R5] one broadband value shared by every filter
// [R6] each filter maps onto any of twelve sets, four programmable, eight fixed; no command here writes sets zero to three except the 515d recopy
// [R7] sets zero to three sit in writable storage, four to eleven are constants
// [R8] fixed sets four to eleven are the listed tones within five percent; the code gives sets four to fifteen one shared parameter set
// [R9] after reset filter n maps to set n
// [R10] at reset sets zero to three hold copies of fixed sets four to seven
// [R11] command 515d recopies sets four to seven, status echoes 515d
// [R12] command 517x writes bits 3-0 into selected filter entry, echoes word
// [R13] host gives mapping values zero to eleven only
// [R14] host selects the filter before issuing the mapping command
// [R15] half-frame in-band energy below threshold gives no detect
// [R16] half-frame in-band above 21/32 of broadband gives detect
// [R17] history of eight half-frames, valid when at least five detects
// [R18] thresholds take codec full scale as 3.14 dBm0 for every input format
// [R19] commands 5154 to 5157 set the selected filter from bits 1-0, echoed
// [R20] one output valid bit per filter
// [R21] energies latched at frame end so both halves belong to one frame
`timescale 1ns/1ns
`include "cptfb_map.vh"
module cptfb_tone_filter_bank (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        sampleValid,
  input  wire [15:0] broadSample,
  input  wire [63:0] bandSample,
  output wire [15:0] mappedSets,
  output wire [3:0]  toneFilterOutputs
);

////////////////////////////////////////////////////////////////////////////////
// command state
reg  [15:0] mapTable;
reg  [1:0]  selectedFilterId;
reg  [15:0] status;
reg  [63:0] progThr;
reg  [63:0] progRatio;
reg  [63:0] progCtl;
reg  [31:0] broadEnergy;
wire [127:0] bandEnergy;
wire [3:0]  toneValid;

// set parameter lookup, word 0 threshold, 1 ratio, 2 history control
function [15:0] paramOf;
  input [3:0]  s;
  input [1:0]  w;
  input [63:0] thrV;
  input [63:0] ratioV;
  input [63:0] ctlV;
  reg   [63:0] src;
  begin
    case (w)
      2'h0:    src = thrV;
      2'h1:    src = ratioV;
      default: src = ctlV;
    endcase
    if (s < `CPTFB_FIRST_FIXED)
      paramOf = src[{s[1:0], 4'h0} +: 16]; // [R6] [R7]
    else
      case (w)
        2'h0:    paramOf = `CPTFB_THR_FIX; // [R8] [R18]
        2'h1:    paramOf = `CPTFB_RATIO_FIX;
        default: paramOf = `CPTFB_HCTL_FIX;
      endcase
  end
endfunction

function [3:0] ones8;
  input [7:0] v;
  integer     k;
  begin
    ones8 = 4'h0;
    for (k = 0; k < 8; k = k + 1)
      ones8 = ones8 + {3'h0, v[k]};
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave
reg         awHeld;
reg  [7:0]  awAddrQ;
reg         wHeld;
reg  [31:0] wDataQ;
reg  [3:0]  wStrbQ;
wire        doWrite = awHeld & wHeld & ~s_axi_bvalid;
wire        cmdFire = doWrite & (awAddrQ == `CPTFB_REG_CMD) & (wStrbQ[1:0] == 2'h3);
wire [15:0] cmd     = wDataQ[15:0];

assign s_axi_awready = ~awHeld;
assign s_axi_wready  = ~wHeld;
assign s_axi_arready = ~s_axi_rvalid;

always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    awHeld       <= 1'b0;
    awAddrQ      <= 8'h00;
    wHeld        <= 1'b0;
    wDataQ       <= 32'h00000000;
    wStrbQ       <= 4'h0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp  <= `CPTFB_RESP_OKAY;
  end
  else
  begin
    if (s_axi_awvalid & ~awHeld)
    begin
      awHeld  <= 1'b1;
      awAddrQ <= s_axi_awaddr;
    end
    else if (doWrite)
      awHeld <= 1'b0;
    if (s_axi_wvalid & ~wHeld)
    begin
      wHeld  <= 1'b1;
      wDataQ <= s_axi_wdata;
      wStrbQ <= s_axi_wstrb;
    end
    else if (doWrite)
      wHeld <= 1'b0;
    if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddrQ == `CPTFB_REG_CMD) ? `CPTFB_RESP_OKAY : `CPTFB_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
end

always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata  <= 32'h00000000;
    s_axi_rresp  <= `CPTFB_RESP_OKAY;
  end
  else if (s_axi_arvalid & ~s_axi_rvalid)
  begin
    s_axi_rvalid <= 1'b1;
    s_axi_rresp  <= `CPTFB_RESP_OKAY;
    case (s_axi_araddr)
      `CPTFB_REG_STATUS: s_axi_rdata <= {16'h0000, status};
      `CPTFB_REG_VALID:  s_axi_rdata <= {28'h0000000, toneValid}; // [R20]
      `CPTFB_REG_MAP:    s_axi_rdata <= {14'h0000, selectedFilterId, mapTable};
      `CPTFB_REG_CMD:    s_axi_rdata <= 32'h00000000;
      default:
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `CPTFB_RESP_SLVERR;
      end
    endcase
  end
  else if (s_axi_rready)
    s_axi_rvalid <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// command decoder
wire [1:0]  eneFilt = cmd[`CPTFB_FLD_FILT];
wire [31:0] eneBand = bandEnergy[{eneFilt, 5'h00} +: 32];
reg  [15:0] eneWord;

always @*
begin
  case (cmd[`CPTFB_FLD_IDX])
    2'h0:    eneWord = broadEnergy[15:0]; // [R2] [R5]
    2'h1:    eneWord = broadEnergy[31:16];
    2'h2:    eneWord = eneBand[15:0];
    default: eneWord = eneBand[31:16];
  endcase
end

always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    mapTable         <= `CPTFB_MAP_RST; // [R9]
    selectedFilterId <= `CPTFB_SEL_RST;
    status           <= `CPTFB_STATUS_RST;
    progThr          <= {4{`CPTFB_THR_FIX}}; // [R10]
    progRatio        <= {4{`CPTFB_RATIO_FIX}};
    progCtl          <= {4{`CPTFB_HCTL_FIX}};
  end
  else if (cmdFire)
  begin
    status <= cmd;
    if (cmd[15:2] == `CPTFB_CMD_SEL_HI)
      selectedFilterId <= cmd[1:0]; // [R19]
    else if (cmd[15:4] == `CPTFB_CMD_ENE_HI)
      status <= eneWord; // [R1]
    else if (cmd[15:4] == `CPTFB_CMD_MAP_HI)
      mapTable[{selectedFilterId, 2'h0} +: 4] <= cmd[`CPTFB_FLD_MAPV]; // [R12] [R14]
    else if (cmd == `CPTFB_CMD_RESTORE)
    begin
      progThr   <= {4{`CPTFB_THR_FIX}}; // [R11]
      progRatio <= {4{`CPTFB_RATIO_FIX}};
      progCtl   <= {4{`CPTFB_HCTL_FIX}};
    end
  end
end

assign mappedSets = mapTable;

////////////////////////////////////////////////////////////////////////////////
// frame timing and broadband energy
reg  [7:0]  sampleCnt;
reg  [35:0] bFrameAcc;
reg  [35:0] bHalfAcc;
wire        frameEnd = sampleValid & (sampleCnt == `CPTFB_FRAME_LAST);
wire        halfEnd  = sampleValid & ((sampleCnt == `CPTFB_FRAME_LAST) |
                                      (sampleCnt == `CPTFB_HALF_LAST));
wire signed [13:0] bq  = broadSample[15:2]; // [R4]
wire signed [27:0] bsq = bq * bq;
wire [35:0] bFrameSum = bFrameAcc + {8'h00, bsq};
wire [35:0] bHalfSum  = bHalfAcc + {8'h00, bsq};
wire [30:0] bHalfE    = bHalfSum[35:`CPTFB_SCALE_SH];

always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    sampleCnt   <= 8'h00;
    bFrameAcc   <= 36'h000000000;
    bHalfAcc    <= 36'h000000000;
    broadEnergy <= 32'h00000000;
  end
  else if (sampleValid)
  begin
    sampleCnt <= frameEnd ? 8'h00 : sampleCnt + 8'h01;
    bFrameAcc <= frameEnd ? 36'h000000000 : bFrameSum;
    bHalfAcc  <= halfEnd ? 36'h000000000 : bHalfSum;
    if (frameEnd)
      broadEnergy <= {1'b0, bFrameSum[35:`CPTFB_SCALE_SH]}; // [R3] [R21]
  end
end

////////////////////////////////////////////////////////////////////////////////
// per filter in-band energy and detection
genvar g;
generate
  for (g = 0; g < 4; g = g + 1)
  begin : filt
    reg  [35:0] fAcc;
    reg  [35:0] hAcc;
    reg  [31:0] energy;
    reg  [7:0]  hist;
    reg         valid;
    wire [3:0]  set   = mapTable[4*g +: 4];
    // parameter words passed in so a reload of the sets re-evaluates them
    wire [15:0] thr   = paramOf(set, 2'h0, progThr, progRatio, progCtl);
    wire [15:0] ratio = paramOf(set, 2'h1, progThr, progRatio, progCtl);
    wire [15:0] hctl  = paramOf(set, 2'h2, progThr, progRatio, progCtl);
    wire signed [13:0] q  = bandSample[16*g+2 +: 14];
    wire signed [27:0] sq = q * q;
    wire [35:0] fSum  = fAcc + {8'h00, sq};
    wire [35:0] hSum  = hAcc + {8'h00, sq};
    wire [31:0] thrSq = thr * thr;
    wire        below = {1'b0, hSum[35:`CPTFB_SCALE_SH]} < thrSq; // [R15]
    wire [47:0] lhs   = {12'h000, hSum[35:`CPTFB_SCALE_SH], 5'h00};
    wire [47:0] rhs   = {32'h00000000, ratio} * {17'h00000, bHalfE};
    wire        det   = ~below & (lhs > rhs); // [R16]
    wire [7:0]  nHist = {hist[6:0], det};
    always @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        fAcc   <= 36'h000000000;
        hAcc   <= 36'h000000000;
        energy <= 32'h00000000;
        hist   <= 8'h00;
        valid  <= 1'b0;
      end
      else if (sampleValid)
      begin
        fAcc <= frameEnd ? 36'h000000000 : fSum;
        hAcc <= halfEnd ? 36'h000000000 : hSum;
        if (halfEnd)
          hist <= nHist; // [R17]
        if (frameEnd)
        begin
          energy <= {1'b0, fSum[35:`CPTFB_SCALE_SH]}; // [R3] [R4] [R21]
          valid  <= ones8(nHist & hctl[11:4]) >= hctl[3:0]; // [R17]
        end
      end
    end
    assign bandEnergy[32*g +: 32] = energy;
    assign toneValid[g]           = valid;
  end
endgenerate

assign toneFilterOutputs = toneValid;

endmodule

// ==== bench/cptfb_checker_sva.sv ====
`timescale 1ns/1ns
module cptfb_checker (
  input wire        clk,
  input wire        rst,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        sampleValid,
  input wire [15:0] mappedSets,
  input wire [3:0]  toneFilterOutputs
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence wrDone;
    ##2 s_axi_bvalid;
  endsequence
  reset_map_a: assert property ($fell(rst) |-> mappedSets == 16'h3210)
    else $error("mapping table not at reset value");
  write_answer_a: assert property (wrTaken |-> wrDone)
    else $error("write response late");
  write_busy_a: assert property (wrTaken |=> !s_axi_awready && !s_axi_wready)
    else $error("write channels not refused while held");
  bvalid_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rvalid_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  valid_steady_a: assert property (
    !$stable(toneFilterOutputs) |-> $past(sampleValid))
    else $error("valid bits moved without a sample");
  map_steady_a: assert property (!$stable(mappedSets) |-> $rose(s_axi_bvalid))
    else $error("mapping moved without a command");
endmodule
bind cptfb_tone_filter_bank cptfb_checker u_chk (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sampleValid, .mappedSets,
  .toneFilterOutputs);

// ==== bench/cptfb_sample_src.sv ====
`timescale 1ns/1ns
module cptfb_sample_src (
  input  wire        clk,
  input  wire        run,
  input  wire [15:0] broad,
  input  wire [63:0] band,
  output reg         sampleValid = 1'b0,
  output reg  [15:0] broadSample = 16'h0000,
  output reg  [63:0] bandSample = 64'h0
);
  reg [1:0] phase = 2'h0;
  // one sample every four cycles, data toggles outside the strobe
  always @(posedge clk)
  begin
    phase <= phase + 2'h1;
    sampleValid <= run && phase == 2'h3;
    broadSample <= (run && phase == 2'h3) ? broad : ~broadSample;
    bandSample <= (run && phase == 2'h3) ? band : ~bandSample;
  end
endmodule

// ==== bench/cptfb_tone_filter_bank_bench.sv ====
`timescale 1ns/1ns
`include "cptfb_map.vh"
module cptfb_tone_filter_bank_bench;
  logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, run;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sampleValid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb, toneFilterOutputs;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] broadSample, mappedSets, broad;
  logic [63:0] bandSample, band;
  int          n_fail, n_compared, cyc;
  cptfb_tone_filter_bank u_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sampleValid, .broadSample, .bandSample, .mappedSets,
    .toneFilterOutputs);
  cptfb_sample_src u_src (.clk, .run, .broad, .band, .sampleValid, .broadSample, .bandSample);
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task finish_test;
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic wa, wd, bv;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge clk);
      wa = s_axi_awready;
      wd = s_axi_wready;
      bv = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk);
      if (wa) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end while (!bv);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    logic ra, rv;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge clk);
      ra = s_axi_arready;
      rv = s_axi_rvalid;
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
      if (ra) s_axi_arvalid <= 1'b0;
    end while (!rv);
    s_axi_rready <= 1'b0;
  endtask
  task cmd(input logic [15:0] w, input logic [15:0] exp, input string what);
    wr(`CPTFB_REG_CMD, {16'h0000, w});
    chk("bresp", {30'h0, `CPTFB_RESP_OKAY}, {30'h0, rsp});
    rd(`CPTFB_REG_STATUS);
    chk(what, {16'h0000, exp}, rdv);
  endtask
  task frames(input int n);
    run <= 1'b1;
    repeat (n * 240)
      do @(posedge clk); while (sampleValid !== 1'b1);
    run <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    wr(`CPTFB_REG_MAP, 32'h0000ffff);
    chk("wrerr", {30'h0, `CPTFB_RESP_SLVERR}, {30'h0, rsp});
    s_axi_wstrb <= 4'hc;
    wr(`CPTFB_REG_CMD, 32'h00005177);
    s_axi_wstrb <= 4'hf;
    rd(`CPTFB_REG_STATUS);
    chk("nostrb", {16'h0000, `CPTFB_STATUS_RST}, rdv);
    rd(`CPTFB_REG_MAP);
    chk("map", 32'h00003210, rdv);
    rd(`CPTFB_REG_VALID);
    chk("valid", 32'h0, rdv);
    rd(8'h10);
    chk("unmapped", {30'h0, `CPTFB_RESP_SLVERR}, {30'h0, rsp});
  endtask
  task t_map;
    logic [3:0] v [4];
    v = '{4'h7, 4'ha, 4'h9, 4'hb};
    for (int g = 0; g < 4; g++)
    begin
      cmd(16'h5154 + g[15:0], 16'h5154 + g[15:0], "select");
      cmd({12'h517, v[g]}, {12'h517, v[g]}, "mapcmd");
    end
    rd(`CPTFB_REG_MAP);
    chk("maptable", 32'h0003b9a7, rdv);
    chk("mappedSets", 32'h0000b9a7, {16'h0, mappedSets});
    cmd(16'h515d, 16'h515d, "restore");
  endtask
  task t_energy;
    broad <= 16'h4000;
    band <= {16'h0040, 16'h0400, 16'h0000, 16'h4000};
    frames(2);
    rd(`CPTFB_REG_VALID);
    chk("valid4", 32'h0, rdv);
    frames(1);
    rd(`CPTFB_REG_VALID);
    chk("valid6", 32'h1, rdv);
    chk("outputs", 32'h1, {28'h0, toneFilterOutputs});
    cmd(16'h5160, 16'h0000, "f0broadlo");
    cmd(16'h5161, 16'h0780, "f0broadhi");
    cmd(16'h5163, 16'h0780, "f0bandhi");
    cmd(16'h5165, 16'h0780, "f1broadhi");
    cmd(16'h516a, 16'h8000, "f2bandlo");
    cmd(16'h516b, 16'h0007, "f2bandhi");
  endtask
  initial
  begin
    rst = 1'b1;
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    run = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    broad = 16'h0000;
    band = 64'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_map;
    t_energy;
    finish_test;
  end
endmodule
